// [design/bstp_tap.sv]
// boundary-scan test access port: tap controller, ir, bypass, boundary chain
// Contract
// - four test pins only: tdi, tdo, tms, tck; no test reset pin
// - all user pins held high impedance while configuring through the port
// - tdi sampled into selected register on rising tck
// - tdo updated with next bit on falling tck
// - tdo high impedance unless shifting ir or a data register
// - tms evaluated and state changed only on rising tck
// - instruction selects the action and the data register in the path
// - one-bit bypass register gives the shortest path
// - all boundary cells chained into one selectable shift register
// - each cell forces its pin or captures pin or core value
// - data shifts tdi through the selected register to tdo
// - tdi feeds the ir while shifting ir; decode steers data registers
// - five tms-high clocks reach test-logic-reset; loads identification
// - instruction register is ten bits; each ir scan shifts ten bits
// - tdo driven from first fall in shift state until first fall after
// - standard sixteen-state tap controller on rising tck
`timescale 1ns/100ps
`default_nettype none
module bstp_tap #(
   parameter int N_PINS = 8
) (
   input  wire logic              sys_clk_in,
   input  wire logic              rst_in,
   input  wire logic              tck_in,
   input  wire logic              tms_in,
   input  wire logic              tdi_in,
   output logic                   tdo_out,
   output logic                   tdo_oe_out,
   input  wire logic [N_PINS-1:0] core_out_in,
   input  wire logic [N_PINS-1:0] core_oe_in,
   input  wire logic [N_PINS-1:0] pin_in,
   output logic      [N_PINS-1:0] core_in_out,
   output logic      [N_PINS-1:0] pin_out,
   output logic      [N_PINS-1:0] pin_oe_out,
   output logic                   config_active_out
);
   localparam int BSR_LEN = 3 * N_PINS;

   typedef struct packed {
      bstp_pkg::bstp_state_type state;
      logic [bstp_pkg::IR_LEN-1:0] ir_sh;
      logic [bstp_pkg::IR_LEN-1:0] ir;
      logic                        bypass;
      logic [31:0]                 id_sh;
      logic [BSR_LEN-1:0]          bsr_sh;
      logic [BSR_LEN-1:0]          bsr_upd;
      logic                        tdo;
      logic                        tdo_oe;
   } bstp_tap_st_type;

   bstp_pkg::bstp_link_type link;
   bstp_tap_st_type st;
   bstp_tap_st_type next_st;
   bstp_pkg::bstp_dr_type dr_sel;
   logic [BSR_LEN-1:0] bsr_cap;
   logic ext_mode;
   logic highz_mode;
   logic shifting;
   logic sel_bit;

   // pins pass two flops before any logic reads them
   bstp_sync u_sync (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .tck_in     (tck_in),
      .tms_in     (tms_in),
      .tdi_in     (tdi_in),
      .link_out   (link)
   );

   ////////////////////////////////////////////////////////////////////////
   // instruction decode
   always_comb begin
      dr_sel = bstp_pkg::BSTP_SEL_BYPASS;
      ext_mode = 1'b0;
      highz_mode = 1'b0;
      if (st.ir == bstp_pkg::INSN_EXTEST) begin
         dr_sel = bstp_pkg::BSTP_SEL_BOUNDARY;
         ext_mode = 1'b1;
      end else if (st.ir == bstp_pkg::INSN_SAMPLE) begin
         dr_sel = bstp_pkg::BSTP_SEL_BOUNDARY;
      end else if (st.ir == bstp_pkg::INSN_IDCODE) begin
         dr_sel = bstp_pkg::BSTP_SEL_ID;
      end else if (st.ir == bstp_pkg::INSN_USERCODE) begin
         dr_sel = bstp_pkg::BSTP_SEL_USER;
      end else if (st.ir == bstp_pkg::INSN_CLAMP) begin
         ext_mode = 1'b1;
      end else if (st.ir == bstp_pkg::INSN_HIGHZ) begin
         highz_mode = 1'b1;
      end
   end

   // configuration mode: user pins parked
   assign config_active_out = (st.ir == bstp_pkg::INSN_CONFIG) &&
                              (st.state != bstp_pkg::BSTP_TLR);

   ////////////////////////////////////////////////////////////////////////
   // boundary cells: out, oe, in per pin
   genvar gi;
   generate
      for (gi = 0; gi < N_PINS; gi++) begin : g_cell
         always_comb begin
            bsr_cap[3*gi+2] = core_out_in[gi];
            bsr_cap[3*gi+1] = core_oe_in[gi];
            bsr_cap[3*gi]   = pin_in[gi];
         end
         always_comb begin
            if (config_active_out || highz_mode) begin
               pin_out[gi]    = 1'b0;
               pin_oe_out[gi] = 1'b0;
            end else if (ext_mode) begin
               pin_out[gi]    = st.bsr_upd[3*gi+2];
               pin_oe_out[gi] = st.bsr_upd[3*gi+1];
            end else begin
               pin_out[gi]    = core_out_in[gi];
               pin_oe_out[gi] = core_oe_in[gi];
            end
            core_in_out[gi] = ext_mode ? st.bsr_upd[3*gi] : pin_in[gi];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // tap controller and registers
   assign shifting = (st.state == bstp_pkg::BSTP_SH_IR) ||
                     (st.state == bstp_pkg::BSTP_SH_DR);

   always_comb begin
      case (dr_sel)
         bstp_pkg::BSTP_SEL_BOUNDARY: sel_bit = st.bsr_sh[0];
         bstp_pkg::BSTP_SEL_ID:       sel_bit = st.id_sh[0];
         bstp_pkg::BSTP_SEL_USER:     sel_bit = st.id_sh[0];
         default:                     sel_bit = st.bypass;
      endcase
   end

   always_comb begin
      next_st = st;
      if (link.tck_rise) begin
         // state moves only on a tck rise
         case (st.state)
            bstp_pkg::BSTP_TLR: next_st.state = link.tms ?
               bstp_pkg::BSTP_TLR : bstp_pkg::BSTP_RTI;
            bstp_pkg::BSTP_RTI: next_st.state = link.tms ?
               bstp_pkg::BSTP_SEL_DR : bstp_pkg::BSTP_RTI;
            bstp_pkg::BSTP_SEL_DR: next_st.state = link.tms ?
               bstp_pkg::BSTP_SEL_IR : bstp_pkg::BSTP_CAP_DR;
            bstp_pkg::BSTP_CAP_DR: next_st.state = link.tms ?
               bstp_pkg::BSTP_EX1_DR : bstp_pkg::BSTP_SH_DR;
            bstp_pkg::BSTP_SH_DR: next_st.state = link.tms ?
               bstp_pkg::BSTP_EX1_DR : bstp_pkg::BSTP_SH_DR;
            bstp_pkg::BSTP_EX1_DR: next_st.state = link.tms ?
               bstp_pkg::BSTP_UPD_DR : bstp_pkg::BSTP_PA_DR;
            bstp_pkg::BSTP_PA_DR: next_st.state = link.tms ?
               bstp_pkg::BSTP_EX2_DR : bstp_pkg::BSTP_PA_DR;
            bstp_pkg::BSTP_EX2_DR: next_st.state = link.tms ?
               bstp_pkg::BSTP_UPD_DR : bstp_pkg::BSTP_SH_DR;
            bstp_pkg::BSTP_UPD_DR: next_st.state = link.tms ?
               bstp_pkg::BSTP_SEL_DR : bstp_pkg::BSTP_RTI;
            bstp_pkg::BSTP_SEL_IR: next_st.state = link.tms ?
               bstp_pkg::BSTP_TLR : bstp_pkg::BSTP_CAP_IR;
            bstp_pkg::BSTP_CAP_IR: next_st.state = link.tms ?
               bstp_pkg::BSTP_EX1_IR : bstp_pkg::BSTP_SH_IR;
            bstp_pkg::BSTP_SH_IR: next_st.state = link.tms ?
               bstp_pkg::BSTP_EX1_IR : bstp_pkg::BSTP_SH_IR;
            bstp_pkg::BSTP_EX1_IR: next_st.state = link.tms ?
               bstp_pkg::BSTP_UPD_IR : bstp_pkg::BSTP_PA_IR;
            bstp_pkg::BSTP_PA_IR: next_st.state = link.tms ?
               bstp_pkg::BSTP_EX2_IR : bstp_pkg::BSTP_PA_IR;
            bstp_pkg::BSTP_EX2_IR: next_st.state = link.tms ?
               bstp_pkg::BSTP_UPD_IR : bstp_pkg::BSTP_SH_IR;
            default: next_st.state = link.tms ?
               bstp_pkg::BSTP_SEL_DR : bstp_pkg::BSTP_RTI;
         endcase

         // register actions belong to the state being left at this rise
         case (st.state)
            bstp_pkg::BSTP_TLR: begin
               next_st.ir = bstp_pkg::INSN_IDCODE;
            end
            bstp_pkg::BSTP_CAP_IR: begin
               next_st.ir_sh = bstp_pkg::IR_CAPTURE;
            end
            bstp_pkg::BSTP_SH_IR: begin
               next_st.ir_sh = {link.tdi, st.ir_sh[bstp_pkg::IR_LEN-1:1]};
            end
            bstp_pkg::BSTP_UPD_IR: begin
               next_st.ir = st.ir_sh;
            end
            bstp_pkg::BSTP_CAP_DR: begin
               next_st.bypass = 1'b0;
               next_st.bsr_sh = bsr_cap;
               next_st.id_sh = (dr_sel == bstp_pkg::BSTP_SEL_USER) ?
                  bstp_pkg::USERCODE_VALUE : bstp_pkg::IDCODE_VALUE;
            end
            bstp_pkg::BSTP_SH_DR: begin
               case (dr_sel)
                  bstp_pkg::BSTP_SEL_BOUNDARY: next_st.bsr_sh =
                     {link.tdi, st.bsr_sh[BSR_LEN-1:1]};
                  bstp_pkg::BSTP_SEL_ID,
                  bstp_pkg::BSTP_SEL_USER: next_st.id_sh =
                     {link.tdi, st.id_sh[31:1]};
                  default: next_st.bypass = link.tdi;
               endcase
            end
            bstp_pkg::BSTP_UPD_DR: begin
               if (dr_sel == bstp_pkg::BSTP_SEL_BOUNDARY) begin
                  next_st.bsr_upd = st.bsr_sh;
               end
            end
            default: begin
            end
         endcase
      end
      if (link.tck_fall) begin
         // tdo follows the shift state at each fall
         next_st.tdo_oe = shifting;
         if (st.state == bstp_pkg::BSTP_SH_IR) begin
            next_st.tdo = st.ir_sh[0];
         end else if (st.state == bstp_pkg::BSTP_SH_DR) begin
            next_st.tdo = sel_bit;
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '{state:   bstp_pkg::BSTP_TLR,
                 ir:      bstp_pkg::INSN_IDCODE,
                 ir_sh:   '0,
                 bypass:  1'b0,
                 id_sh:   '0,
                 bsr_sh:  '0,
                 bsr_upd: '0,
                 tdo:     1'b0,
                 tdo_oe:  1'b0};
      end else begin
         st <= next_st;
      end
   end

   // only tck, tms, tdi in and tdo out form the port
   assign tdo_out    = st.tdo;
   assign tdo_oe_out = st.tdo_oe;
endmodule // bstp_tap
`default_nettype wire

// [design/bstp_pkg.sv]
// package for the boundary-scan test port: states, codes, lengths, carriers
package bstp_pkg;

   // instruction register length and a few instruction codes
   localparam int IR_LEN = 10;
   localparam int TLR_TMS_ONES = 5;
   localparam logic [9:0] INSN_EXTEST    = 10'h000;
   localparam logic [9:0] INSN_SAMPLE    = 10'h005;
   localparam logic [9:0] INSN_IDCODE    = 10'h006;
   localparam logic [9:0] INSN_USERCODE  = 10'h007;
   localparam logic [9:0] INSN_CLAMP     = 10'h00A;
   localparam logic [9:0] INSN_HIGHZ     = 10'h00B;
   localparam logic [9:0] INSN_CONFIG    = 10'h002;
   localparam logic [9:0] INSN_BYPASS    = 10'h3FF;
   // fixed low bits captured into the instruction register
   localparam logic [9:0] IR_CAPTURE     = 10'h001;
   // arbitrary identification value, not a real part
   localparam logic [31:0] IDCODE_VALUE  = 32'h1234_5679;
   localparam logic [31:0] USERCODE_VALUE = 32'hFFFF_FFFF;

   typedef enum logic [3:0] {
      BSTP_TLR, BSTP_RTI, BSTP_SEL_DR, BSTP_CAP_DR, BSTP_SH_DR, BSTP_EX1_DR,
      BSTP_PA_DR, BSTP_EX2_DR, BSTP_UPD_DR, BSTP_SEL_IR, BSTP_CAP_IR,
      BSTP_SH_IR, BSTP_EX1_IR, BSTP_PA_IR, BSTP_EX2_IR, BSTP_UPD_IR
   } bstp_state_type;

   typedef enum logic [2:0] {
      BSTP_SEL_BYPASS, BSTP_SEL_BOUNDARY, BSTP_SEL_ID, BSTP_SEL_USER
   } bstp_dr_type;

   // synchronised link pins and their tck edges
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic tck_rise;
      logic tck_fall;
   } bstp_link_type;

endpackage : bstp_pkg

// [design/bstp_sync.sv]
// two-flop synchroniser and edge finder for the tap pins
`timescale 1ns/100ps
`default_nettype none
module bstp_sync (
   input  wire logic             sys_clk_in,
   input  wire logic             rst_in,
   input  wire logic             tck_in,
   input  wire logic             tms_in,
   input  wire logic             tdi_in,
   output bstp_pkg::bstp_link_type link_out
);
   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] sync;
      logic       tck_old;
   } bstp_sync_st_type;

   bstp_sync_st_type st;
   bstp_sync_st_type next_st;

   always_comb begin
      next_st = st;
      next_st.meta = {tck_in, tms_in, tdi_in};
      next_st.sync = st.meta;
      next_st.tck_old = st.sync[2];
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         // idle levels: tms high keeps the controller in reset
         st <= '{meta: 3'b010, sync: 3'b010, tck_old: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      link_out.tck      = st.sync[2];
      link_out.tms      = st.sync[1];
      link_out.tdi      = st.sync[0];
      link_out.tck_rise = st.sync[2] & ~st.tck_old;
      link_out.tck_fall = ~st.sync[2] & st.tck_old;
   end
endmodule // bstp_sync
`default_nettype wire

// [verif/bstp_tester.sv]
// model of the external test controller that drives the tap pins
`timescale 1ns/100ps
`default_nettype none
module bstp_tester (
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out,
   input  wire logic tdo_in,
   input  wire logic tdo_oe_in
);
   // idle with tck low and tms high so the port rests in reset
   initial begin
      tck_out = 1'h0;
      tms_out = 1'h1;
      tdi_out = 1'h1;
   end
   // one tck period, entered while tck is low just after a fall
   task automatic step(input logic tms, input logic tdi,
                       output logic tdo, output logic oe);
      tms_out = tms;
      tdi_out = tdi;
      #24;
      tdo = tdo_in;
      oe = tdo_oe_in;
      tck_out = 1'h1;
      #24;
      tck_out = 1'h0;
   endtask
endmodule // bstp_tester
`default_nettype wire

// [verif/bstp_tap_checker.sv]
// assertion checker for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
module bstp_tap_checker #(
   parameter int N_PINS = 8
) (
   input wire logic              sys_clk_in,
   input wire logic              rst_in,
   input wire logic              tck_in,
   input wire logic              tms_in,
   input wire logic              tdi_in,
   input wire logic              tdo_out,
   input wire logic              tdo_oe_out,
   input wire logic [N_PINS-1:0] core_out_in,
   input wire logic [N_PINS-1:0] core_oe_in,
   input wire logic [N_PINS-1:0] pin_in,
   input wire logic [N_PINS-1:0] core_in_out,
   input wire logic [N_PINS-1:0] pin_out,
   input wire logic [N_PINS-1:0] pin_oe_out,
   input wire logic              config_active_out
);
   // own view of tck rises; ones counts tms-high rises, saturating at 7
   logic [2:0] ck;
   logic [1:0] tm;
   logic       last_tms;
   logic [2:0] ones;
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ck <= 3'h0;
         tm <= 2'h3;
         last_tms <= 1'h1;
         ones <= 3'h5;
      end else begin
         ck <= {ck[1:0], tck_in};
         tm <= {tm[0], tms_in};
         if (ck[1] & ~ck[2]) begin
            last_tms <= tm[1];
            ones <= tm[1] ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
         end
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   tdo_fall_a: assert property ($changed(tdo_out) |-> !tck_in)
      else $error("tdo moved while tck high");
   oe_fall_a: assert property ($changed(tdo_oe_out) |-> !tck_in)
      else $error("tdo enable moved while tck high");
   oe_hold_a: assert property ($rose(tdo_oe_out) |-> tdo_oe_out[*8])
      else $error("tdo enable dropped early");
   oe_release_a: assert property ($fell(tdo_oe_out) |-> !tdo_oe_out[*8])
      else $error("tdo enable returned early");
   shift_entry_a: assert property ($rose(tdo_oe_out) |-> !last_tms)
      else $error("tdo enabled without tms low");
   shift_exit_a: assert property ($fell(tdo_oe_out) |-> last_tms)
      else $error("tdo released without tms high");
   config_hiz_a: assert property (config_active_out |-> !(|pin_oe_out))
      else $error("pin driven while configuring");
   tlr_idle_a: assert property (ones >= 3'h6 |->
      !tdo_oe_out && !config_active_out)
      else $error("test logic active in reset state");
   normal_pins_a: assert property (ones >= 3'h6 |->
      pin_out == core_out_in && pin_oe_out == core_oe_in &&
      core_in_out == pin_in)
      else $error("pins not in normal mode in reset state");
   cover property ($rose(tdo_oe_out));
   cover property ($rose(config_active_out));
   cover property (ones == 3'h5 && ck[1] && !ck[2]);
endmodule // bstp_tap_checker
bind bstp_tap bstp_tap_checker #(.N_PINS(N_PINS)) u_bstp_tap_checker (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .tck_in(tck_in),
   .tms_in(tms_in), .tdi_in(tdi_in), .tdo_out(tdo_out),
   .tdo_oe_out(tdo_oe_out), .core_out_in(core_out_in),
   .core_oe_in(core_oe_in), .pin_in(pin_in), .core_in_out(core_in_out),
   .pin_out(pin_out), .pin_oe_out(pin_oe_out),
   .config_active_out(config_active_out));
`default_nettype wire

// [verif/tb_bstp_tap.sv]
// self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
module tb_bstp_tap;
   localparam int NP = 8;
   logic          sys_clk_in;
   logic          rst_in;
   logic          tck, tms, tdi, tdo, tdo_oe, cfg;
   logic [NP-1:0] core_out, core_oe, pin_in, core_in, pin_out, pin_oe;
   logic [95:0]   dout;
   int            n_errors = 0;
   int            comparisons = 0;
   int            cycles = 0;
   bstp_tap #(.N_PINS(NP)) u_bstp_tap (.sys_clk_in(sys_clk_in),
      .rst_in(rst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
      .tdo_out(tdo), .tdo_oe_out(tdo_oe), .core_out_in(core_out),
      .core_oe_in(core_oe), .pin_in(pin_in), .core_in_out(core_in),
      .pin_out(pin_out), .pin_oe_out(pin_oe), .config_active_out(cfg));
   bstp_tester u_bstp_tester (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
      .tdo_in(tdo), .tdo_oe_in(tdo_oe));
   initial sys_clk_in = 1'h0;
   always #2.5 sys_clk_in = ~sys_clk_in;
   // a full run needs a few thousand cycles
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [95:0] exp,
                        input logic [95:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic tlr();
      logic b, o;
      repeat (6) u_bstp_tester.step(1'h1, 1'h1, b, o);
      u_bstp_tester.step(1'h0, 1'h1, b, o);
   endtask
   // from idle: one ir or dr scan of n bits, lsb first, back to idle
   task automatic scan(input bit ir, input int n, input logic [95:0] din);
      logic b, o, bad;
      dout = 96'h0;
      u_bstp_tester.step(1'h1, 1'h0, b, o);
      if (ir) u_bstp_tester.step(1'h1, 1'h0, b, o);
      u_bstp_tester.step(1'h0, 1'h0, b, o);
      u_bstp_tester.step(1'h0, 1'h0, b, o);
      bad = o;
      for (int k = 0; k < n; k++) begin
         u_bstp_tester.step(k == n - 1, din[k], b, o);
         dout[k] = b;
         bad = bad | (o !== 1'h1);
      end
      u_bstp_tester.step(1'h1, 1'h0, b, o);
      bad = bad | (o !== 1'h0);
      u_bstp_tester.step(1'h0, 1'h0, b, o);
      check("tdo enable", 96'h0, {95'h0, bad});
   endtask
   task automatic test_id();
      tlr();
      scan(0, 32, 96'h0);
      check("idcode", {64'h0, bstp_pkg::IDCODE_VALUE}, dout);
      scan(1, 10, {86'h0, bstp_pkg::INSN_USERCODE});
      check("ir capture", {86'h0, bstp_pkg::IR_CAPTURE}, dout);
      scan(0, 32, 96'h0);
      check("usercode", {64'h0, bstp_pkg::USERCODE_VALUE}, dout);
      $display("test_id done");
   endtask
   task automatic test_bypass();
      logic [9:0] codes [2];
      codes = '{bstp_pkg::INSN_BYPASS, 10'h155};
      foreach (codes[c]) begin
         scan(1, 10, {86'h0, codes[c]});
         scan(0, 9, 96'h0a5);
         check("bypass path", 96'h14a, dout);
      end
      $display("test_bypass done");
   endtask
   task automatic test_boundary();
      logic [95:0]   cap, pat;
      logic [NP-1:0] eo, ee, ei;
      pat = 96'h96_5a3c;
      @(posedge sys_clk_in);
      #1;
      core_out = 8'h3c;
      core_oe = 8'h96;
      pin_in = 8'h5a;
      cap = 96'h0;
      for (int i = 0; i < NP; i++) begin
         cap[3*i+:3] = {core_out[i], core_oe[i], pin_in[i]};
         {eo[i], ee[i], ei[i]} = pat[3*i+:3];
      end
      scan(1, 10, {86'h0, bstp_pkg::INSN_SAMPLE});
      scan(0, 3 * NP, pat);
      check("sample capture", cap, dout);
      check("sample pins", {88'h0, core_out}, {88'h0, pin_out});
      scan(1, 10, {86'h0, bstp_pkg::INSN_EXTEST});
      scan(0, 3 * NP, pat);
      check("extest capture", cap, dout);
      check("extest out", {88'h0, eo}, {88'h0, pin_out});
      check("extest oe", {88'h0, ee}, {88'h0, pin_oe});
      check("extest core", {88'h0, ei}, {88'h0, core_in});
      scan(1, 10, {86'h0, bstp_pkg::INSN_CLAMP});
      scan(0, 2, 96'h3);
      check("clamp path", 96'h2, dout);
      check("clamp pins", {88'h0, eo}, {88'h0, pin_out});
      $display("test_boundary done");
   endtask
   task automatic test_config();
      scan(1, 10, {86'h0, bstp_pkg::INSN_CONFIG});
      check("config flag", 96'h1, {95'h0, cfg});
      check("config oe", 96'h0, {88'h0, pin_oe});
      scan(1, 10, {86'h0, bstp_pkg::INSN_HIGHZ});
      check("highz oe", 96'h0, {88'h0, pin_oe});
      tlr();
      check("normal pins", {88'h0, core_out}, {88'h0, pin_out});
      check("normal oe", {88'h0, core_oe}, {88'h0, pin_oe});
      $display("test_config done");
   endtask
   initial begin
      rst_in = 1'h1;
      core_out = 8'h00;
      core_oe = 8'h00;
      pin_in = 8'h00;
      repeat (5) @(posedge sys_clk_in);
      #1;
      rst_in = 1'h0;
      repeat (3) @(posedge sys_clk_in);
      check("reset tdo enable", 96'h0, {95'h0, tdo_oe});
      test_id();
      test_bypass();
      test_boundary();
      test_config();
      give_verdict();
   end
endmodule // tb_bstp_tap
`default_nettype wire
